/* rtl/twcd_params.svh */
`ifndef TWCD_PARAMS_SVH
`define TWCD_PARAMS_SVH

// register byte offsets on the bus
`define TWCD_OFF_UNIT_CTRL  8'h00
`define TWCD_OFF_PRESCALE   8'h04
`define TWCD_OFF_MODE       8'h08
`define TWCD_OFF_TRIGGER    8'h0c
`define TWCD_OFF_ENABLE     8'h10
`define TWCD_OFF_DATA       8'h14
`define TWCD_OFF_COUNT      8'h18
`define TWCD_OFF_STATUS     8'h1c
`define TWCD_OFF_OUTPUT     8'h20

// field positions
`define TWCD_UNIT_EN_BIT    0
`define TWCD_START_BIT      0
`define TWCD_STOP_BIT       1
`define TWCD_OVF_BIT        0
`define TWCD_MODE_DELAY_BIT 0
`define TWCD_EDGE_LO_BIT    1
`define TWCD_EDGE_HI_BIT    2
`define TWCD_CLK_SEL_BIT    3
`define TWCD_COUPLE_BIT     4

// widths
`define TWCD_CNT_W          16
`define TWCD_MODE_W         5
`define TWCD_OUT_W          4
`define TWCD_PSC_W          8
`define TWCD_DIV_W          16

// reset and fixed values
`define TWCD_RST_MODE       5'h00
`define TWCD_RST_PSC        8'h00
`define TWCD_RST_OUT        4'h0
`define TWCD_RST_CNT        16'h0000
`define TWCD_CNT_ZERO       16'h0000
`define TWCD_CNT_FULL       16'hffff
`define TWCD_BYTE_FULL      8'hff

`endif

/* rtl/twcd_pkg.sv */
package twcd_pkg;
  // channel sequencer states, one-hot
  typedef enum logic [2:0] {
    TWCD_ST_IDLE = 3'b001,
    TWCD_ST_WAIT = 3'b010,
    TWCD_ST_RUN  = 3'b100
  } twcd_state_t;
endpackage : twcd_pkg

/* rtl/twcd_tick_if.sv */
`timescale 1ns/10ps
`default_nettype none
// tick and edge strobes shared between the channel and its helpers
interface twcd_tick_if;
  logic tick_a;   // first prescaled enable
  logic tick_b;   // second prescaled enable
  logic op_tick;  // selected operating clock enable
  logic rise;     // sampled rising edge of timer input
  logic fall;     // sampled falling edge of timer input
  modport presc (output tick_a, output tick_b);
  modport edge_det (input op_tick, output rise, output fall);
  modport core (input tick_a, input tick_b, input rise, input fall, output op_tick);
endinterface : twcd_tick_if
`default_nettype wire

/* rtl/twcd_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
`include "twcd_params.svh"
// two power-of-two dividers sharing one free counter
module twcd_prescaler
  import twcd_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   run,
  input  wire logic [`TWCD_PSC_W-1:0] psc_sel,
  twcd_tick_if.presc                  tk
);
  logic [`TWCD_DIV_W-1:0] div_reg;  // free running divider
  logic [1:0]             tick;     // one enable per prescaled clock

  // divider only runs while the unit clock is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= `TWCD_RST_CNT;
    end else if (!run) begin
      div_reg <= `TWCD_RST_CNT;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // low bits all ones marks one period of 2^sel cycles
  for (genvar g = 0; g < 2; g++) begin : g_tick
    logic [`TWCD_DIV_W-1:0] mask;  // low ones of width sel
    assign mask    = (16'h0001 << psc_sel[g*4 +: 4]) - 16'h0001;
    assign tick[g] = run && ((div_reg & mask) == mask);
  end

  assign tk.tick_a = tick[0];
  assign tk.tick_b = tick[1];
endmodule : twcd_prescaler
`default_nettype wire

/* rtl/twcd_edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// synchronises the timer input and samples it on the operating clock
module twcd_edge_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  input  wire logic pin_in,
  twcd_tick_if.edge_det tk
);
  logic meta_reg;  // first stage, read only by sync_reg
  logic sync_reg;  // second stage
  logic samp_reg;  // level seen at the last operating clock

  // two stage synchroniser against the asynchronous pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  // sampling on the slow enable costs up to one operating cycle of delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_reg <= 1'b0;
    end else if (!run) begin
      samp_reg <= sync_reg;
    end else if (tk.op_tick) begin
      samp_reg <= sync_reg;
    end
  end

  assign tk.rise = run && tk.op_tick && sync_reg && !samp_reg;
  assign tk.fall = run && tk.op_tick && !sync_reg && samp_reg;
endmodule : twcd_edge_sync
`default_nettype wire

/* rtl/twcd_channel.sv */
// What this block does
// - width mode: start edge clears count, counts up
// - capture edge copies count, raises interrupt
// - overflow bit set or cleared at capture
// - after capture, stop and await next start
// - start sets enable, width waits start edge
// - start and stop triggers read back zero
// - stop clears enable, holds count and overflow
// - delay mode trigger loads data into count
// - delay count decrements once per count clock
// - zero gives interrupt, parks count at FFFFH (split channel: low byte at FFH)
// - trigger to interrupt is data plus one
// - delay mode start while enabled triggers
// - data writable anytime, used at next load
// - split channel delay uses lower byte only
// - input sampled on operating clock
// - unit off: clock stopped, registers reset
// - clock select bit picks prescaled clock
// - data, count, status readable without disturbance
// - coupling bit fixed zero on channel zero
// - edge bits 10 low width, 11 high width
// - width mode start ignored while enabled
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "twcd_params.svh"
module twcd_channel
  import twcd_pkg::*;
#(
  parameter int CHAN_IDX = 1  // channel number 0 to 3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        timer_input_pin,
  output logic             chan_output_bit,
  output logic             chan_irq
);
  twcd_tick_if tk ();  // strobes between helpers

  // bus phase state
  logic                    dp_wr_reg;    // data phase is a write
  logic [7:0]              dp_addr_reg;  // data phase address
  logic [31:0]             rdata_reg;    // read data for the data phase
  logic                    ap_take;      // address phase accepted
  // software registers
  logic                    unit_en_reg;  // timer_unit_enable
  logic [`TWCD_PSC_W-1:0]  psc_reg;      // prescaler_select_reg
  logic [`TWCD_MODE_W-1:0] mode_reg;     // chan_mode_reg
  logic [`TWCD_OUT_W-1:0]  out_reg;      // output bit, enable, level, mode
  logic [`TWCD_CNT_W-1:0]  data_reg;     // chan_data_reg
  // channel state
  logic [`TWCD_CNT_W-1:0]  count_reg;    // chan_count_reg
  logic                    en_reg;       // chan_enable_status
  logic                    ovf_reg;      // overflow_flag
  logic                    ovf_pend_reg; // overflow seen in this measurement
  logic                    irq_reg;      // interrupt pulse
  logic                    sw_trig_reg;  // pending software trigger
  twcd_state_t             state_reg;    // sequencer
  // decoded strobes
  logic                    wr_ok;        // write accepted by unit
  logic                    start_pls;    // chan_start_trigger written 1
  logic                    stop_pls;     // chan_stop_trigger written 1
  logic                    mode_delay;   // delay counter mode
  logic                    split8;       // lower byte only
  logic                    start_edge;   // width start edge
  logic                    cap_edge;     // width capture edge
  logic                    dly_trig;     // delay trigger (pin or software)
  logic                    cnt_zero;     // down count at zero
  logic                    step;         // channel active on this tick
  logic                    cap_now;      // capture happens now
  logic                    done_now;     // delay expiry happens now
  logic [`TWCD_CNT_W-1:0]  load_val;     // value loaded at trigger

  // helpers: prescaler and input sampler
  twcd_prescaler u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (unit_en_reg),
    .psc_sel (psc_reg),
    .tk      (tk.presc)
  );
  twcd_edge_sync u_edge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (unit_en_reg),
    .pin_in  (timer_input_pin),
    .tk      (tk.edge_det)
  );

  // operating clock from the clock select bit
  assign tk.op_tick = mode_reg[`TWCD_CLK_SEL_BIT] ? tk.tick_b : tk.tick_a;

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign ap_take   = hsel && htrans[1] && hready;

  // address phase capture, read data prepared for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      dp_wr_reg   <= ap_take && hwrite;
      dp_addr_reg <= haddr[7:0];
      if (ap_take && !hwrite) begin
        // reads never touch channel state
        if (!unit_en_reg && haddr[7:0] != `TWCD_OFF_UNIT_CTRL) begin
          rdata_reg <= 32'h0000_0000;  // unit off hides registers
        end else begin
          unique case (haddr[7:0])
            `TWCD_OFF_UNIT_CTRL: rdata_reg <= {31'h0, unit_en_reg};
            `TWCD_OFF_PRESCALE:  rdata_reg <= {24'h0, psc_reg};
            `TWCD_OFF_MODE:      rdata_reg <= {27'h0, mode_reg};
            `TWCD_OFF_ENABLE:    rdata_reg <= {31'h0, en_reg};
            `TWCD_OFF_DATA:      rdata_reg <= {16'h0, data_reg};
            `TWCD_OFF_COUNT:     rdata_reg <= {16'h0, count_reg};
            `TWCD_OFF_STATUS:    rdata_reg <= {31'h0, ovf_reg};
            `TWCD_OFF_OUTPUT:    rdata_reg <= {28'h0, out_reg};
            default:             rdata_reg <= 32'h0000_0000;  // trigger, unmapped
          endcase
        end
      end
    end
  end

  // writes land in the data phase; unit off ignores all but unit control
  assign wr_ok     = dp_wr_reg && unit_en_reg;
  assign start_pls = wr_ok && dp_addr_reg == `TWCD_OFF_TRIGGER && hwdata[`TWCD_START_BIT];
  assign stop_pls  = wr_ok && dp_addr_reg == `TWCD_OFF_TRIGGER && hwdata[`TWCD_STOP_BIT];

  // unit enable lives outside the unit reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_en_reg <= 1'b0;
    end else if (dp_wr_reg && dp_addr_reg == `TWCD_OFF_UNIT_CTRL) begin
      unit_en_reg <= hwdata[`TWCD_UNIT_EN_BIT];
    end
  end

  // configuration registers, cleared while the unit is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_reg  <= `TWCD_RST_PSC;
      mode_reg <= `TWCD_RST_MODE;
      out_reg  <= `TWCD_RST_OUT;
    end else if (!unit_en_reg) begin
      psc_reg  <= `TWCD_RST_PSC;
      mode_reg <= `TWCD_RST_MODE;
      out_reg  <= `TWCD_RST_OUT;
    end else if (wr_ok) begin
      if (dp_addr_reg == `TWCD_OFF_PRESCALE) begin
        psc_reg <= hwdata[`TWCD_PSC_W-1:0];
      end
      if (dp_addr_reg == `TWCD_OFF_MODE) begin
        mode_reg <= hwdata[`TWCD_MODE_W-1:0];
        if (CHAN_IDX == 0) begin
          mode_reg[`TWCD_COUPLE_BIT] <= 1'b0;  // no partner below
        end
      end
      if (dp_addr_reg == `TWCD_OFF_OUTPUT) begin
        out_reg <= hwdata[`TWCD_OUT_W-1:0];  // kept zero by software
      end
    end
  end
  assign chan_output_bit = out_reg[0];

  // mode decode
  assign mode_delay = mode_reg[`TWCD_MODE_DELAY_BIT];
  // coupling bit splits channels 1 and 3; on 2 it only marks a master
  assign split8 = mode_delay && mode_reg[`TWCD_COUPLE_BIT] && (CHAN_IDX == 1 || CHAN_IDX == 3);
  // lo=1 high width: rise starts, fall captures; lo=0 the reverse
  assign start_edge = mode_reg[`TWCD_EDGE_LO_BIT] ? tk.rise : tk.fall;
  assign cap_edge   = mode_reg[`TWCD_EDGE_LO_BIT] ? tk.fall : tk.rise;
  assign dly_trig   = start_edge || sw_trig_reg;
  assign cnt_zero   = split8 ? count_reg[7:0] == 8'h00 : count_reg == `TWCD_CNT_ZERO;
  assign load_val   = split8 ? {8'h00, data_reg[7:0]} : data_reg;
  assign step       = tk.op_tick && en_reg && !stop_pls;
  assign cap_now    = step && !mode_delay && state_reg == TWCD_ST_RUN && cap_edge;
  assign done_now   = step && mode_delay && state_reg == TWCD_ST_RUN && !dly_trig && cnt_zero;

  // channel enable status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg <= 1'b0;
    end else if (!unit_en_reg || stop_pls) begin
      en_reg <= 1'b0;
    end else if (start_pls) begin
      en_reg <= 1'b1;
    end
  end

  // software trigger waits for the next operating tick; new set beats consume
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_trig_reg <= 1'b0;
    end else if (!unit_en_reg || stop_pls) begin
      sw_trig_reg <= 1'b0;
    end else if (start_pls && en_reg && mode_delay) begin
      sw_trig_reg <= 1'b1;
    end else if (tk.op_tick) begin
      sw_trig_reg <= 1'b0;
    end
  end

  // sequencer and counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= TWCD_ST_IDLE;
      count_reg <= `TWCD_RST_CNT;
    end else if (!unit_en_reg) begin
      state_reg <= TWCD_ST_IDLE;
      count_reg <= `TWCD_RST_CNT;
    end else if (stop_pls) begin
      state_reg <= TWCD_ST_IDLE;  // count holds
    end else if (start_pls && !en_reg) begin
      state_reg <= TWCD_ST_WAIT;
    end else if (step) begin
      unique case (state_reg)
        TWCD_ST_IDLE: begin
          state_reg <= TWCD_ST_IDLE;  // stopped, nothing counts
        end
        TWCD_ST_WAIT: begin
          if (!mode_delay && start_edge) begin
            count_reg <= `TWCD_CNT_ZERO;
            state_reg <= TWCD_ST_RUN;
          end else if (mode_delay && dly_trig) begin
            count_reg <= load_val;
            state_reg <= TWCD_ST_RUN;
          end
        end
        TWCD_ST_RUN: begin
          if (!mode_delay) begin
            count_reg <= count_reg + 16'h0001;
            if (cap_edge) begin
              state_reg <= TWCD_ST_WAIT;  // parks at capture plus one
            end
          end else if (dly_trig) begin
            count_reg <= load_val;  // retrigger restarts the delay
          end else if (cnt_zero) begin
            // expiry after data plus one ticks
            count_reg <= split8 ? {count_reg[15:8], `TWCD_BYTE_FULL} : `TWCD_CNT_FULL;
            state_reg <= TWCD_ST_WAIT;
          end else if (split8) begin
            count_reg <= {count_reg[15:8], count_reg[7:0] - 8'h01};
          end else begin
            count_reg <= count_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= TWCD_ST_IDLE;
        end
      endcase
    end
  end

  // overflow during a measurement; cleared at each start edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_pend_reg <= 1'b0;
    end else if (!unit_en_reg) begin
      ovf_pend_reg <= 1'b0;
    end else if (step && !mode_delay && state_reg == TWCD_ST_WAIT && start_edge) begin
      ovf_pend_reg <= 1'b0;
    end else if (step && !mode_delay && state_reg == TWCD_ST_RUN
                 && count_reg == `TWCD_CNT_FULL) begin
      ovf_pend_reg <= 1'b1;
    end
  end

  // visible overflow flag follows each capture, set or cleared there, and is also cleared while the unit is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_reg <= 1'b0;
    end else if (!unit_en_reg) begin
      ovf_reg <= 1'b0;
    end else if (cap_now) begin
      ovf_reg <= ovf_pend_reg;  // set or cleared
    end
  end

  // data register: capture wins over a same-cycle write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= `TWCD_RST_CNT;
    end else if (!unit_en_reg) begin
      data_reg <= `TWCD_RST_CNT;
    end else if (cap_now) begin
      data_reg <= count_reg;
    end else if (wr_ok && dp_addr_reg == `TWCD_OFF_DATA) begin
      data_reg <= hwdata[`TWCD_CNT_W-1:0];  // any time
    end
  end

  // interrupt held for exactly one operating clock period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else if (!unit_en_reg) begin
      irq_reg <= 1'b0;
    end else if (cap_now || done_now) begin
      irq_reg <= 1'b1;
    end else if (tk.op_tick) begin
      irq_reg <= 1'b0;
    end
  end
  assign chan_irq = irq_reg;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_width_start;
    step && !mode_delay && state_reg == TWCD_ST_WAIT && start_edge && !start_pls;
  endsequence
  sequence s_cleared_running;
    count_reg == `TWCD_CNT_ZERO && state_reg == TWCD_ST_RUN;
  endsequence

  a_width_start_clr: assert property (s_width_start |=> s_cleared_running)
    else $error("start edge did not clear count");
  a_capture_copy: assert property (cap_now |=> data_reg == $past(count_reg) && irq_reg
                                   && state_reg == TWCD_ST_WAIT)
    else $error("capture did not copy count");
  a_capture_ovf: assert property (cap_now |=> ovf_reg == $past(ovf_pend_reg))
    else $error("overflow flag wrong after capture");
  a_start_enable: assert property (start_pls && !stop_pls |=> en_reg)
    else $error("start did not enable");
  a_trigger_reads: assert property (ap_take && !hwrite && haddr[7:0] == `TWCD_OFF_TRIGGER
                                    |=> hrdata == 32'h0000_0000)
    else $error("trigger register read nonzero");
  a_stop_holds: assert property (stop_pls && unit_en_reg |=> !en_reg
                                 && $stable(count_reg) && $stable(ovf_reg))
    else $error("stop did not freeze channel");
  a_delay_expiry: assert property (done_now && !split8 |=> count_reg == `TWCD_CNT_FULL
                                   && irq_reg ##1 ($stable(count_reg) || $past(!unit_en_reg)
                                   || $past(step && dly_trig)))
    else $error("delay expiry wrong");
  a_delay_step: assert property (step && mode_delay && state_reg == TWCD_ST_RUN && !dly_trig
                                 && !cnt_zero && !split8
                                 |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("down count did not step by one");
  a_width_start_ign: assert property (start_pls && en_reg && !mode_delay && !stop_pls
                                      |=> $stable(state_reg) || $past(step))
    else $error("start accepted while enabled");
  a_irq_one_tick: assert property (irq_reg && tk.op_tick && !cap_now && !done_now
                                   |=> !irq_reg)
    else $error("interrupt longer than one tick");
  a_unit_off: assert property (!unit_en_reg |=> !en_reg && count_reg == `TWCD_RST_CNT)
    else $error("unit off did not reset");
  a_chan0_couple: assert property (CHAN_IDX != 0 || !mode_reg[`TWCD_COUPLE_BIT])
    else $error("channel zero coupling bit set");
endmodule : twcd_channel
`default_nettype wire

/* dv/twcd_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far side: drives the timer input with one pulse per request
module twcd_pin_model (
  input  wire logic        hclk,
  input  wire logic        fire,   // pulse request strobe
  input  wire logic [17:0] len,    // pulse length in hclk cycles
  input  wire logic        level,  // active level of the pulse
  output logic             pin     // timer input pin
);
  int left = 0;  // cycles of the pulse still to drive
  // idles at the inverse level, so a pulse always begins with its start edge
  always @(posedge hclk) begin
    if (fire) left <= len;
    else if (left > 0) left <= left - 1;
    pin <= (fire || left > 1) ? level : !level;
  end
endmodule : twcd_pin_model
`default_nettype wire

/* dv/twcd_channel_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "twcd_params.svh"
module twcd_channel_bench;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fire = 0, level = 1, rd_chk = 0;
  logic [1:0]  htrans = 0;     // bus transfer kind
  logic [2:0]  hsize  = 3'h2;  // always a whole word
  logic [31:0] haddr  = 0, hwdata = 0;
  logic [17:0] len    = 0;     // pulse length for the pin model
  wire logic   hreadyout, hresp, pin, chan_irq, obit;
  wire logic [31:0] hrdata;
  logic [31:0] exp_q[$];       // expected read data, oldest first
  int mismatches = 0, cmp_count = 0, cyc = 0, rnd, d, t0, n, l;
  always #2 hclk = !hclk;
  twcd_channel i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_input_pin(pin),
    .chan_output_bit(obit), .chan_irq(chan_irq));
  twcd_pin_model i_pin (.hclk(hclk), .fire(fire), .len(len), .level(level), .pin(pin));
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // single transfer; for a read, dv is the expected word
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] dv);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= dv;
    if (!wr) begin
      exp_q.push_back(dv);
      rd_chk <= 1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_chk <= 0;
  endtask : bus
  // cycles until the interrupt, then its width must be one tick
  task wait_irq(output int cnt, input int per);
    cnt = 0;
    while (chan_irq !== 1'b1) begin
      @(negedge hclk);
      cnt++;
    end
    repeat (per - 1) @(negedge hclk);
    chk("irq held", 32'h1, {31'h0, chan_irq});
    @(negedge hclk);
    chk("irq width", 32'h0, {31'h0, chan_irq});
  endtask : wait_irq
  task pulse(input int pl);
    @(posedge hclk);
    len <= 18'(pl); fire <= 1;
    @(posedge hclk);
    fire <= 0;
  endtask : pulse
  // read data monitor: oldest note against the word in the data phase
  always @(posedge hclk) begin
    if (rd_chk && exp_q.size() > 0) chk("read data", exp_q.pop_front(), hrdata);
    if (rd_chk) chk("response", 32'h0, {31'h0, hresp});
  end
  // hang guard, sized above the long overflow pulse
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    rnd = $urandom(10);
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    bus(0, `TWCD_OFF_MODE, 0);
    bus(1, `TWCD_OFF_DATA, 5);
    bus(0, `TWCD_OFF_DATA, 0);
    bus(1, `TWCD_OFF_UNIT_CTRL, 1);
    bus(1, `TWCD_OFF_OUTPUT, 0);
    bus(0, `TWCD_OFF_OUTPUT, 0);
    chk("output bit", 32'h0, {31'h0, obit});
    bus(0, 8'h24, 0);
    bus(1, `TWCD_OFF_PRESCALE, 32'h20);
    $display("register access test done");
    // delay counter on both prescaled clocks (per 1 and per 4)
    for (int sel = 0; sel < 2; sel++) begin
      l = sel ? 4 : 1;
      bus(1, `TWCD_OFF_TRIGGER, 2);
      bus(1, `TWCD_OFF_MODE, 32'h1 | (sel << 3));
      bus(1, `TWCD_OFF_TRIGGER, 1);
      bus(0, `TWCD_OFF_ENABLE, 1);
      bus(0, `TWCD_OFF_TRIGGER, 0);
      for (int k = 0; k < 2; k++) begin
        d = k ? ($urandom % 30 + 1) : 0;
        bus(1, `TWCD_OFF_DATA, 32'(d));
        bus(1, `TWCD_OFF_TRIGGER, 1);
        wait_irq(n, l);
        if (k == 0) t0 = n;
        bus(0, `TWCD_OFF_COUNT, 32'hffff);
      end
      chk("delay span", 1, ((n - t0 > l * (d - 1)) && (n - t0 < l * (d + 1))));
    end
    // split channel: only the low byte loads and counts, so 3 ticks plus one
    bus(1, `TWCD_OFF_TRIGGER, 2);
    bus(1, `TWCD_OFF_MODE, 32'h11);
    bus(1, `TWCD_OFF_DATA, 32'h1203);
    bus(1, `TWCD_OFF_TRIGGER, 1);
    bus(1, `TWCD_OFF_TRIGGER, 1);
    wait_irq(n, 1);
    chk("split span", 32'd6, 32'(n));
    bus(0, `TWCD_OFF_COUNT, 32'h00ff);
    $display("delay counter test done");
    // high width: one overflowing pulse, then a short one
    bus(1, `TWCD_OFF_TRIGGER, 2);
    bus(1, `TWCD_OFF_MODE, 32'h6);
    bus(1, `TWCD_OFF_TRIGGER, 1);
    for (int k = 0; k < 2; k++) begin
      l = k ? ($urandom % 40 + 3) : 65540;
      pulse(l);
      wait_irq(n, 1);
      bus(0, `TWCD_OFF_DATA, 32'((l - 1) % 65536));
      bus(0, `TWCD_OFF_STATUS, k ? 0 : 1);
    end
    bus(1, `TWCD_OFF_TRIGGER, 2);
    bus(0, `TWCD_OFF_ENABLE, 0);
    bus(0, `TWCD_OFF_COUNT, 32'(l));
    $display("high width test done");
    // low width after a stop and restart
    level <= 0;
    bus(1, `TWCD_OFF_MODE, 32'h4);
    bus(1, `TWCD_OFF_TRIGGER, 1);
    l = $urandom % 40 + 3;
    pulse(l);
    wait_irq(n, 1);
    bus(0, `TWCD_OFF_DATA, 32'(l - 1));
    bus(1, `TWCD_OFF_UNIT_CTRL, 0);
    bus(0, `TWCD_OFF_DATA, 0);
    $display("low width test done");
    finish_test();
  end
endmodule : twcd_channel_bench
`default_nettype wire
